// *** hw/uart_ctl_pkg.sv ***
`default_nettype none
package uart_ctl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 9;

  localparam logic [ADDR_W-1:0] OFF_CONTROL_TWO = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FORMAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h18;

  localparam int unsigned FMT_NINE_BIT = 0;
  localparam int unsigned FMT_NINTH_RX = 1;
  localparam int unsigned ST_PORT_IRQ = 0;
  localparam int unsigned ST_WAKE_REQ = 1;
  localparam int unsigned ST_CLK_ON = 2;
  localparam int unsigned BIT_SEVEN = 7;
  localparam int unsigned BIT_NINTH = 8;

  localparam logic [5:0] PRESCALE_LOW_LAST = 6'h3F;
  localparam logic [5:0] PRESCALE_HIGH_LAST = 6'h0F;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
  localparam logic [2:0] EVENT_RESET = 3'h0;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic baud_high_speed_select;
    logic address_detect_enable;
    logic wake_enable;
    logic receive_irq_enable;
    logic tx_idle_irq_enable;
    logic tx_empty_irq_enable;
  } uart_control_two_t;

  typedef struct packed {
    logic discarded_word;
    logic address_word;
    logic wake;
  } event_bits_t;

  typedef struct packed {
    logic overrun_flag;
    logic rx_data_ready_flag;
    logic tx_idle_flag;
    logic tx_buffer_empty_flag;
  } port_flags_t;
endpackage : uart_ctl_pkg
`default_nettype wire

// *** hw/uart_addr_detect_wake_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_addr_detect_wake_irq_ctrl
  import uart_ctl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rx_pin,
  input wire logic i_port_clock_on,
  input wire logic i_rx_word_valid,
  input wire logic [WORD_W-1:0] i_rx_word,
  input wire port_flags_t i_flags,
  output logic o_rx_data_valid,
  output logic [WORD_W-1:0] o_rx_data,
  output logic o_received_ninth_bit,
  output logic o_baud_tick,
  output uart_control_two_t o_control,
  output logic o_nine_bit_select,
  output logic o_wake_request,
  output logic o_port_irq_flag,
  output logic o_irq
);

  uart_control_two_t ctrl_r;
  logic [7:0] baud_divisor_r;
  logic nine_bit_r;
  logic ninth_r;
  event_bits_t status_r;
  event_bits_t mask_r;
  logic [WORD_W-1:0] rx_data_r;
  logic rx_data_valid_r;
  logic wake_req_r;
  logic port_irq_r;
  logic irq_r;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W-1:0] prdata_r;
  logic [5:0] prescale_r;
  logic [7:0] div_r;
  logic tick_r;

  // rx pin and clock gate come from outside this domain
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;
  logic clk_meta_r;
  logic clk_on_r;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
      clk_meta_r <= 1'b0;
      clk_on_r <= 1'b0;
    end else begin
      rx_meta_r <= i_rx_pin;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
      clk_meta_r <= i_port_clock_on;
      clk_on_r <= clk_meta_r;
    end
  end

  // apb decode
  wire access = i_psel && i_penable;
  wire done = access && pready_r;
  wire wr_done = done && i_pwrite;
  wire rd_done = done && !i_pwrite;
  wire hit_ctrl = (i_paddr == OFF_CONTROL_TWO);
  wire hit_baud = (i_paddr == OFF_BAUD_DIVISOR);
  wire hit_fmt = (i_paddr == OFF_FORMAT);
  wire hit_stat = (i_paddr == OFF_EVENT_STATUS);
  wire hit_mask = (i_paddr == OFF_EVENT_MASK);
  wire hit_rxd = (i_paddr == OFF_RX_DATA);
  wire hit_state = (i_paddr == OFF_STATE);
  wire mapped = hit_ctrl | hit_baud | hit_fmt | hit_stat | hit_mask | hit_rxd | hit_state;

  wire [DATA_W-1:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_r} :
    hit_baud ? {24'h000000, baud_divisor_r} :
    hit_fmt ? {30'h00000000, ninth_r, nine_bit_r} :
    hit_stat ? {29'h00000000, status_r} :
    hit_mask ? {29'h00000000, mask_r} :
    hit_rxd ? {23'h000000, rx_data_r} :
    hit_state ? {29'h00000000, clk_on_r, wake_req_r, port_irq_r} :
    32'h00000000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !mapped;
      if (access && !pready_r) begin
        prdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= CONTROL_TWO_RESET;
      baud_divisor_r <= BAUD_DIVISOR_RESET;
      nine_bit_r <= 1'b0;
      mask_r <= EVENT_RESET;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl_r <= i_pwdata[7:0];
      end
      if (hit_baud) begin
        baud_divisor_r <= i_pwdata[7:0];
      end
      if (hit_fmt) begin
        nine_bit_r <= i_pwdata[FMT_NINE_BIT];
      end
      if (hit_mask) begin
        mask_r <= i_pwdata[2:0];
      end
    end
  end

  // baud generator, paused while the port clock is off
  wire [5:0] prescale_last = ctrl_r.baud_high_speed_select ? PRESCALE_HIGH_LAST
                                                           : PRESCALE_LOW_LAST;
  wire prescale_end = (prescale_r >= prescale_last);
  wire div_end = (div_r >= baud_divisor_r);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prescale_r <= 6'h00;
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= clk_on_r && prescale_end && div_end;
      if (clk_on_r) begin
        prescale_r <= prescale_end ? 6'h00 : prescale_r + 6'h01;
        if (prescale_end) begin
          div_r <= div_end ? 8'h00 : div_r + 8'h01;
        end
      end
    end
  end

  // address detection on received words
  wire addr_bit = nine_bit_r ? i_rx_word[BIT_NINTH] : i_rx_word[BIT_SEVEN];
  wire is_address = ctrl_r.address_detect_enable && addr_bit;
  wire discard = ctrl_r.address_detect_enable && !addr_bit;
  wire deliver = i_rx_word_valid && !discard;
  wire addr_word = i_rx_word_valid && is_address;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_data_valid_r <= 1'b0;
      rx_data_r <= 9'h000;
      ninth_r <= 1'b0;
    end else begin
      rx_data_valid_r <= deliver;
      if (deliver) begin
        rx_data_r <= i_rx_word;
        if (nine_bit_r) begin
          ninth_r <= i_rx_word[BIT_NINTH];
        end
      end
    end
  end

  // wake-up edge works on the free-running clock, not on the gated port clock
  wire rx_fall = rx_prev_r && !rx_sync_r;
  wire wake_set = rx_fall && !clk_on_r && ctrl_r.wake_enable;

  // request holds until software turns the port clock back on
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wake_req_r <= 1'b0;
    end else if (wake_set) begin
      wake_req_r <= 1'b1;
    end else if (clk_on_r) begin
      wake_req_r <= 1'b0;
    end
  end

  // shared port request flag
  wire rx_src = ctrl_r.receive_irq_enable
                && (i_flags.overrun_flag || i_flags.rx_data_ready_flag);
  wire addr_src = ctrl_r.receive_irq_enable && addr_word;
  wire idle_src = ctrl_r.tx_idle_irq_enable && i_flags.tx_idle_flag;
  wire empty_src = ctrl_r.tx_empty_irq_enable && i_flags.tx_buffer_empty_flag;
  wire port_irq_nxt = rx_src || addr_src || idle_src || empty_src;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      port_irq_r <= 1'b0;
    end else if (clk_on_r) begin
      port_irq_r <= port_irq_nxt;
    end
  end

  // sticky events; a set in the clearing read's cycle survives
  event_bits_t evt_set;
  assign evt_set = '{discarded_word: i_rx_word_valid && discard,
                     address_word: addr_word,
                     wake: wake_set};
  wire stat_clear = rd_done && hit_stat;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      status_r <= EVENT_RESET;
      irq_r <= 1'b0;
    end else begin
      status_r <= (stat_clear ? EVENT_RESET : status_r) | evt_set;
      irq_r <= |(((stat_clear ? EVENT_RESET : status_r) | evt_set) & mask_r);
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_rx_data_valid = rx_data_valid_r;
  assign o_rx_data = rx_data_r;
  assign o_received_ninth_bit = ninth_r;
  assign o_baud_tick = tick_r;
  assign o_control = ctrl_r;
  assign o_nine_bit_select = nine_bit_r;
  assign o_wake_request = wake_req_r;
  assign o_port_irq_flag = port_irq_r;
  assign o_irq = irq_r;

  // assertion helpers: cycles between ticks, config change since last tick
  logic [15:0] gap_r;
  logic cfg_chg_r;
  wire [15:0] period = ({10'h000, prescale_last} + 16'h0001)
                       * ({8'h00, baud_divisor_r} + 16'h0001);
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_r <= 16'h0000;
      cfg_chg_r <= 1'b1;
    end else begin
      gap_r <= tick_r ? 16'h0001 : (clk_on_r ? gap_r + 16'h0001 : gap_r);
      cfg_chg_r <= tick_r ? 1'b0 : (cfg_chg_r || (wr_done && (hit_ctrl || hit_baud)) || !clk_on_r);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  property p_baud_period;
    tick_r && !cfg_chg_r |-> gap_r == period;
  endproperty
  a_baud_period: assert property (p_baud_period) else $error("baud tick spacing wrong");

  property p_high_low_speed;
    clk_on_r && prescale_r == PRESCALE_HIGH_LAST && !ctrl_r.baud_high_speed_select
      |=> prescale_r == PRESCALE_HIGH_LAST + 6'h01 || !$stable(ctrl_r) || !clk_on_r;
  endproperty
  a_high_low_speed: assert property (p_high_low_speed) else $error("low speed wrapped early");

  property p_addr_deliver;
    i_rx_word_valid && (!ctrl_r.address_detect_enable || addr_bit)
      |=> o_rx_data_valid && o_rx_data == $past(i_rx_word);
  endproperty
  a_addr_deliver: assert property (p_addr_deliver) else $error("word not delivered");

  property p_addr_discard;
    i_rx_word_valid && ctrl_r.address_detect_enable && !addr_bit
      |=> !o_rx_data_valid && $stable(o_rx_data);
  endproperty
  a_addr_discard: assert property (p_addr_discard) else $error("data word not discarded");

  property p_addr_irq;
    addr_word && ctrl_r.receive_irq_enable && clk_on_r |=> o_port_irq_flag;
  endproperty
  a_addr_irq: assert property (p_addr_irq) else $error("address word raised no request");

  property p_wake_only_stopped;
    $rose(o_wake_request) |-> !$past(clk_on_r) && $past(ctrl_r.wake_enable);
  endproperty
  a_wake_only_stopped: assert property (p_wake_only_stopped) else $error("bad wake");

  property p_wake_set;
    rx_fall && !clk_on_r && ctrl_r.wake_enable |=> o_wake_request ##1 o_irq || !mask_r.wake;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake request missing");

  property p_wake_off;
    !ctrl_r.wake_enable && !o_wake_request |=> !o_wake_request;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");

  property p_rx_irq;
    clk_on_r && ctrl_r.receive_irq_enable && i_flags.overrun_flag |=> o_port_irq_flag;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("overrun raised no request");

  property p_rx_masked;
    clk_on_r && !ctrl_r.receive_irq_enable && !idle_src && !empty_src |=> !o_port_irq_flag;
  endproperty
  a_rx_masked: assert property (p_rx_masked) else $error("request without source");

  property p_idle;
    clk_on_r && ctrl_r.tx_idle_irq_enable && i_flags.tx_idle_flag |=> o_port_irq_flag;
  endproperty
  a_idle: assert property (p_idle) else $error("idle raised no request");

  property p_empty;
    clk_on_r && ctrl_r.tx_empty_irq_enable && i_flags.tx_buffer_empty_flag |=> o_port_irq_flag;
  endproperty
  a_empty: assert property (p_empty) else $error("empty raised no request");

  property p_ninth;
    deliver && nine_bit_r |=> o_received_ninth_bit == $past(i_rx_word[BIT_NINTH]);
  endproperty
  a_ninth: assert property (p_ninth) else $error("ninth bit not kept");

  // sources rebuilt from the raw flags rather than from the flop's own input
  property p_or_sources;
    clk_on_r |=> o_port_irq_flag == $past(
      (ctrl_r.receive_irq_enable && (i_flags.overrun_flag || i_flags.rx_data_ready_flag
                                     || (i_rx_word_valid && is_address)))
      || (ctrl_r.tx_idle_irq_enable && i_flags.tx_idle_flag)
      || (ctrl_r.tx_empty_irq_enable && i_flags.tx_buffer_empty_flag));
  endproperty
  a_or_sources: assert property (p_or_sources) else $error("request flag not OR");

  property p_flag_frozen;
    !clk_on_r |=> $stable(o_port_irq_flag);
  endproperty
  a_flag_frozen: assert property (p_flag_frozen) else $error("flag moved while stopped");

  property p_wake_clear;
    clk_on_r |=> !o_wake_request;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake while clock runs");

  property p_discard_event;
    i_rx_word_valid && discard |=> status_r.discarded_word;
  endproperty
  a_discard_event: assert property (p_discard_event) else $error("discard not recorded");

endmodule : uart_addr_detect_wake_irq_ctrl
`default_nettype wire

// *** tb/serial_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_peer
  import uart_ctl_pkg::*;
(
  input wire logic i_clock,
  output logic o_rx_pin,
  output logic o_word_valid,
  output logic [WORD_W-1:0] o_word
);
  initial begin
    o_rx_pin = 1'b1;
    o_word_valid = 1'b0;
    o_word = '0;
  end
  // one word per call, handed over as a single-cycle pulse
  task automatic send_word(input logic [WORD_W-1:0] w);
    @(posedge i_clock);
    o_word_valid <= 1'b1;
    o_word <= w;
    @(posedge i_clock);
    o_word_valid <= 1'b0;
    // stale bus shows the inverse so a late sample cannot match
    o_word <= ~w;
  endtask : send_word
  // start bit only: enough for a falling edge, line idles high after
  task automatic start_bit();
    @(posedge i_clock);
    o_rx_pin <= 1'b0;
    repeat (8) @(posedge i_clock);
    o_rx_pin <= 1'b1;
  endtask : start_bit
endmodule : serial_peer
`default_nettype wire

// *** tb/uart_addr_detect_wake_irq_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_addr_detect_wake_irq_ctrl_tb
  import uart_ctl_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, q;
  logic pready, pslverr, last_err;
  logic rx_pin, word_valid, clk_on = 1'b1;
  logic [WORD_W-1:0] word, rx_data;
  port_flags_t flags = '0;
  logic rx_valid, ninth, tick, nine_sel, wake_req, port_irq, irq;
  uart_control_two_t control;
  int errors = 0;
  int samples_checked = 0;
  int p;
  logic [7:0] rows [10] = '{8'h91, 8'h89, 8'h18, 8'h45, 8'h04, 8'h23, 8'h02, 8'hE0, 8'h5F, 8'hA4};
  logic [10:0] words [4] = '{11'h280, 11'h07F, 11'h700, 11'h4FF};

  always #2.5 i_clock = ~i_clock;

  serial_peer i_serial_peer (.i_clock(i_clock), .o_rx_pin(rx_pin), .o_word_valid(word_valid),
    .o_word(word));

  uart_addr_detect_wake_irq_ctrl i_uart_addr_detect_wake_irq_ctrl (.i_clock(i_clock),
    .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_rx_pin(rx_pin), .i_port_clock_on(clk_on), .i_rx_word_valid(word_valid),
    .i_rx_word(word), .i_flags(flags), .o_rx_data_valid(rx_valid), .o_rx_data(rx_data),
    .o_received_ninth_bit(ninth), .o_baud_tick(tick), .o_control(control),
    .o_nine_bit_select(nine_sel), .o_wake_request(wake_req), .o_port_irq_flag(port_irq),
    .o_irq(irq));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    // request held up to the edge that samples pready; only the watchdog ends the wait
    do begin
      @(posedge i_clock);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_check(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    check(what, q, e);
  endtask : rd_check

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle

  // first tick found may straddle a mode change, so the caller discards it
  task automatic period();
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 1000) begin
      @(negedge i_clock);
      n++;
    end
    p = 0;
    do begin
      @(negedge i_clock);
      p++;
    end while (tick !== 1'b1 && p < 1000);
  endtask : period

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge i_clock);
    errors++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge i_clock);
      flags <= rows[i][4:1];
      apb(1'b1, OFF_CONTROL_TWO, {29'h0, rows[i][7:5]});
      settle(2);
      check("port irq flag", 32'(port_irq), 32'(rows[i][0]));
    end
    $display("test flag gating done");
    @(posedge i_clock);
    flags <= '0;
    rd_check("control", OFF_CONTROL_TWO, 32'h0000_0005);
    rd_check("unmapped", 8'h1C, 32'h0);
    check("slverr", 32'(last_err), 32'h1);
    apb(1'b1, OFF_BAUD_DIVISOR, 32'h1);
    apb(1'b1, OFF_CONTROL_TWO, 32'h20);
    @(negedge i_clock);
    check("high speed out", 32'(control.baud_high_speed_select), 32'h1);
    period();
    period();
    check("high speed period", 32'(p), 32'd32);
    apb(1'b1, OFF_CONTROL_TWO, 32'h00);
    period();
    period();
    check("low speed period", 32'(p), 32'd128);
    $display("test baud done");
    apb(1'b1, OFF_CONTROL_TWO, 32'h14);
    foreach (words[i]) begin
      apb(1'b1, OFF_FORMAT, {31'h0, words[i][10]});
      i_serial_peer.send_word(words[i][8:0]);
      @(negedge i_clock);
      check("delivered", 32'(rx_valid), 32'(words[i][9]));
      check("address irq", 32'(port_irq), 32'(words[i][9]));
      check("nine bit select", 32'(nine_sel), 32'(words[i][10]));
      if (words[i][9]) begin
        check("rx data", 32'(rx_data), 32'(words[i][8:0]));
        check("ninth bit", 32'(ninth), 32'(words[i][8]));
      end
    end
    rd_check("format", OFF_FORMAT, 32'h3);
    rd_check("rx data reg", OFF_RX_DATA, 32'h100);
    rd_check("events", OFF_EVENT_STATUS, 32'h6);
    rd_check("events cleared", OFF_EVENT_STATUS, 32'h0);
    $display("test address detect done");
    apb(1'b1, OFF_CONTROL_TWO, 32'h08);
    apb(1'b1, OFF_EVENT_MASK, 32'h1);
    i_serial_peer.start_bit();
    settle(4);
    check("wake while running", 32'(wake_req), 32'h0);
    @(posedge i_clock);
    clk_on <= 1'b0;
    settle(4);
    i_serial_peer.start_bit();
    settle(4);
    check("wake request", 32'(wake_req), 32'h1);
    check("wake irq", 32'(irq), 32'h1);
    rd_check("wake event", OFF_EVENT_STATUS, 32'h1);
    // the port never restarts its own clock
    @(posedge i_clock);
    clk_on <= 1'b1;
    settle(4);
    check("wake released", 32'(wake_req), 32'h0);
    check("irq cleared", 32'(irq), 32'h0);
    apb(1'b1, OFF_CONTROL_TWO, 32'h00);
    clk_on <= 1'b0;
    settle(4);
    i_serial_peer.start_bit();
    settle(4);
    check("wake disabled", 32'(wake_req), 32'h0);
    rd_check("no wake event", OFF_EVENT_STATUS, 32'h0);
    $display("test wake done");
    apb(1'b1, OFF_CONTROL_TWO, 32'h3F);
    apb(1'b1, OFF_BAUD_DIVISOR, 32'h12);
    @(posedge i_clock);
    i_rstn <= 1'b0;
    settle(1);
    check("reset control", 32'(control), 32'h0);
    check("reset nine bit", 32'(nine_sel), 32'h0);
    check("reset ninth", 32'(ninth), 32'h0);
    check("reset rx data", 32'(rx_data), 32'h0);
    check("reset port irq", 32'(port_irq), 32'h0);
    @(posedge i_clock);
    i_rstn <= 1'b1;
    rd_check("baud after reset", OFF_BAUD_DIVISOR, 32'h0);
    rd_check("state after reset", OFF_STATE, 32'h0);
    $display("test reset done");
    test_done();
  end
endmodule : uart_addr_detect_wake_irq_ctrl_tb
`default_nettype wire
